//--- core/qsn_consts.svh
/*
 status node constants: bit positions, reset and preset values, error queue sizes and codes.
 assumes inclusion by bare name from core/ files.
*/
`ifndef QSN_CONSTS_SVH
`define QSN_CONSTS_SVH
`define QSN_W            16
`define QSN_BIT_COH      7
`define QSN_BIT_TEMP     9
`define QSN_BIT_PROT     10
`define QSN_USED_MASK    16'h0680
`define QSN_OPER_USED    16'h0300
`define QSN_BIT_OPER_EXC 8
`define QSN_BIT_OPER_INI 9
`define QSN_RST_ENABLE   16'h0000
`define QSN_RST_RISE     16'h0000
`define QSN_RST_FALL     16'h0000
`define QSN_PRE_ENABLE   16'h0000
`define QSN_PRE_RISE     16'hFFFF
`define QSN_PRE_FALL     16'h0000
`define QSN_ERR_DEPTH    8
`define QSN_ERR_PW       3
`define QSN_ERR_CNTW     4
`define QSN_ERR_NONE     16'sh0000
`define QSN_ERR_OVERFLOW 16'shFEBC
`endif

//--- core/qsn_pkg.sv
/*
 types of the status node.
 assumes nothing else.
*/
package qsn_pkg;
   // register selector carried by a command
   typedef enum logic [3:0] {
      QSN_SEL_QCOND, QSN_SEL_QEVENT, QSN_SEL_QENABLE, QSN_SEL_QRISE, QSN_SEL_QFALL,
      QSN_SEL_OCOND, QSN_SEL_OEVENT, QSN_SEL_OENABLE, QSN_SEL_ORISE, QSN_SEL_OFALL,
      QSN_SEL_ERROR, QSN_SEL_PRESET
   } qsn_sel_t;
endpackage : qsn_pkg

//--- core/qsn_node.sv
/*
 one status node: condition, transition filters, event latch, enable, summary.
 assumes condition inputs are synchronous to clk and reads/writes are pulses.
*/
`timescale 1ns/1ps
`include "qsn_consts.svh"
module qsn_node (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // monitored states, already restricted to used bits
   input  wire logic [15:0]       cond_in,
   // register writes
   input  wire logic              wr_enable,
   input  wire logic              wr_rise,
   input  wire logic              wr_fall,
   input  wire logic [15:0]       wr_data,
   input  wire logic              preset,
   input  wire logic              rd_event,
   // state
   output logic      [15:0]       cond_r,
   output logic      [15:0]       event_r,
   output logic      [15:0]       enable_r,
   output logic      [15:0]       rise_r,
   output logic      [15:0]       fall_r,
   output logic                   summary_r
);
   logic [15:0] prev_r;    // condition one clock back
   logic [15:0] hit;       // filtered edges

   // condition follows states every clock, reading never touches it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_r <= 16'h0000;
         prev_r <= 16'h0000;
      end else begin
         cond_r <= cond_in;
         prev_r <= cond_r;
      end
   end

   // edges per bit gated by the two filters
   genvar i;
   for (i = 0; i < `QSN_W; i++) begin : g_edge
      assign hit[i] = (rise_r[i] & cond_r[i] & ~prev_r[i])
                    | (fall_r[i] & ~cond_r[i] & prev_r[i]);
   end

   // event latch: set wins over the read clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) event_r <= 16'h0000;
      else if (rd_event) event_r <= hit;
      else event_r <= event_r | hit;
   end

   // filters and enable, preset overrides a same-cycle write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         enable_r <= `QSN_RST_ENABLE;
         rise_r   <= `QSN_RST_RISE;
         fall_r   <= `QSN_RST_FALL;
      end else if (preset) begin
         enable_r <= `QSN_PRE_ENABLE;
         rise_r   <= `QSN_PRE_RISE;
         fall_r   <= `QSN_PRE_FALL;
      end else begin
         if (wr_enable) enable_r <= wr_data;
         if (wr_rise)   rise_r   <= wr_data;
         if (wr_fall)   fall_r   <= wr_data;
      end
   end

   // summary: or of enabled event bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) summary_r <= 1'b0;
      else summary_r <= |(event_r & enable_r);
   end
endmodule : qsn_node

//--- core/qsn_top.sv
/*
 questionable and operation status nodes with error queue, reached by decoded
 text-command strobes from the instrument bus parser.
 assumes commands are one-cycle strobes synchronous to clk.
*/
// How it works
// - bit 7: coherence on and power too low
// - bit 9: chamber temperature still stabilizing
// - bit 10: output off protecting diode
// - only questionable event bits 7, 9, 10 set
// - falling mask enables one-to-zero event set
// - rising mask enables zero-to-one event set
// - preset: enables 0, rise 1, fall 0
// - error read gives signed code, zero none
// - reading event register clears it
// - condition tracks states, read leaves unchanged
// - enabled event bits drive status bit 3
`timescale 1ns/1ps
`include "qsn_consts.svh"
module qsn_top (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // monitored states
   input  wire logic              coh_active,
   input  wire logic              power_below_limit,
   input  wire logic              temp_unstable,
   input  wire logic              output_protect_off,
   input  wire logic              power_excess,
   input  wire logic              initializing,
   // command strobe from the text parser
   input  wire logic              cmd_valid,
   input  wire logic              cmd_write,
   input  wire qsn_pkg::qsn_sel_t cmd_sel,
   input  wire logic [15:0]       cmd_data,
   // error producer
   input  wire logic              err_push,
   input  wire logic [15:0]       err_code,
   input  wire logic [7:0]        err_text,
   // answers
   output logic                   rsp_valid,
   output logic      [15:0]       rsp_data,
   output logic      [7:0]        rsp_text,
   // status byte summaries
   output logic                   stb_ques,
   output logic                   stb_oper
);
   logic       rst_s1_r, rst_n;   // reset release synchroniser
   logic [15:0] q_cond, q_event, q_enable, q_rise, q_fall;
   logic [15:0] o_cond, o_event, o_enable, o_rise, o_fall;
   logic        q_sum, o_sum;
   logic [15:0] q_in, o_in;
   logic        rd, wr;
   logic signed [15:0] err_code_mem [`QSN_ERR_DEPTH];  // error codes
   logic [7:0]  err_text_mem [`QSN_ERR_DEPTH];         // short text token
   logic [`QSN_ERR_PW-1:0]  wp_r, rp_r;
   logic [`QSN_ERR_CNTW-1:0] cnt_r;
   logic        err_pop, err_wr;

   // asynchronous assert, synchronous release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n    <= rst_s1_r;
      end
   end

   assign rd = cmd_valid & ~cmd_write;
   assign wr = cmd_valid & cmd_write;

   // only the documented bits exist; others stay zero so events never set
   always_comb begin
      q_in = 16'h0000;
      q_in[`QSN_BIT_COH]  = coh_active & power_below_limit;
      q_in[`QSN_BIT_TEMP] = temp_unstable;
      q_in[`QSN_BIT_PROT] = output_protect_off;
      o_in = 16'h0000;
      o_in[`QSN_BIT_OPER_EXC] = power_excess;
      o_in[`QSN_BIT_OPER_INI] = initializing;
   end

   qsn_node u_ques (
      .clk       (clk),
      .rst_n     (rst_n),
      .cond_in   (q_in),
      .wr_enable (wr && cmd_sel == qsn_pkg::QSN_SEL_QENABLE),
      .wr_rise   (wr && cmd_sel == qsn_pkg::QSN_SEL_QRISE),
      .wr_fall   (wr && cmd_sel == qsn_pkg::QSN_SEL_QFALL),
      .wr_data   (cmd_data),
      .preset    (cmd_valid && cmd_sel == qsn_pkg::QSN_SEL_PRESET),
      .rd_event  (rd && cmd_sel == qsn_pkg::QSN_SEL_QEVENT),
      .cond_r    (q_cond),
      .event_r   (q_event),
      .enable_r  (q_enable),
      .rise_r    (q_rise),
      .fall_r    (q_fall),
      .summary_r (q_sum)
   );

   qsn_node u_oper (
      .clk       (clk),
      .rst_n     (rst_n),
      .cond_in   (o_in),
      .wr_enable (wr && cmd_sel == qsn_pkg::QSN_SEL_OENABLE),
      .wr_rise   (wr && cmd_sel == qsn_pkg::QSN_SEL_ORISE),
      .wr_fall   (wr && cmd_sel == qsn_pkg::QSN_SEL_OFALL),
      .wr_data   (cmd_data),
      .preset    (cmd_valid && cmd_sel == qsn_pkg::QSN_SEL_PRESET),
      .rd_event  (rd && cmd_sel == qsn_pkg::QSN_SEL_OEVENT),
      .cond_r    (o_cond),
      .event_r   (o_event),
      .enable_r  (o_enable),
      .rise_r    (o_rise),
      .fall_r    (o_fall),
      .summary_r (o_sum)
   );

   // summaries already registered in the nodes; one more stage keeps ports on flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stb_ques <= 1'b0;
         stb_oper <= 1'b0;
      end else begin
         stb_ques <= q_sum;
         stb_oper <= o_sum;
      end
   end

   // error queue: a full queue replaces the newest entry with an overflow code
   assign err_pop = rd && cmd_sel == qsn_pkg::QSN_SEL_ERROR && cnt_r != '0;
   assign err_wr  = err_push && err_code != `QSN_ERR_NONE;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
      end else begin
         if (err_wr && (cnt_r != `QSN_ERR_CNTW'(`QSN_ERR_DEPTH) || err_pop))
            wp_r <= wp_r + 1'b1;
         if (err_pop) rp_r <= rp_r + 1'b1;
         if (err_wr && !err_pop && cnt_r != `QSN_ERR_CNTW'(`QSN_ERR_DEPTH))
            cnt_r <= cnt_r + 1'b1;
         else if (err_pop && !err_wr)
            cnt_r <= cnt_r - 1'b1;
      end
   end

   // queue storage; no reset needed as count guards reads
   always_ff @(posedge clk) begin
      if (err_wr) begin
         if (cnt_r == `QSN_ERR_CNTW'(`QSN_ERR_DEPTH) && !err_pop) begin
            err_code_mem[wp_r - 1'b1] <= `QSN_ERR_OVERFLOW;
            err_text_mem[wp_r - 1'b1] <= 8'h00;
         end else begin
            err_code_mem[wp_r] <= err_code;
            err_text_mem[wp_r] <= err_text;
         end
      end
   end

   // read answers, one cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_valid <= 1'b0;
         rsp_data  <= 16'h0000;
         rsp_text  <= 8'h00;
      end else begin
         rsp_valid <= rd;
         rsp_text  <= 8'h00;
         unique case (cmd_sel)
            qsn_pkg::QSN_SEL_QCOND:   rsp_data <= q_cond;
            qsn_pkg::QSN_SEL_QEVENT:  rsp_data <= q_event;
            qsn_pkg::QSN_SEL_QENABLE: rsp_data <= q_enable;
            qsn_pkg::QSN_SEL_QRISE:   rsp_data <= q_rise;
            qsn_pkg::QSN_SEL_QFALL:   rsp_data <= q_fall;
            qsn_pkg::QSN_SEL_OCOND:   rsp_data <= o_cond;
            qsn_pkg::QSN_SEL_OEVENT:  rsp_data <= o_event;
            qsn_pkg::QSN_SEL_OENABLE: rsp_data <= o_enable;
            qsn_pkg::QSN_SEL_ORISE:   rsp_data <= o_rise;
            qsn_pkg::QSN_SEL_OFALL:   rsp_data <= o_fall;
            qsn_pkg::QSN_SEL_ERROR: begin
               // empty queue answers code zero, meaning no error
               rsp_data <= (cnt_r != '0) ? err_code_mem[rp_r] : `QSN_ERR_NONE;
               rsp_text <= (cnt_r != '0) ? err_text_mem[rp_r] : 8'h00;
            end
            qsn_pkg::QSN_SEL_PRESET:  rsp_data <= 16'h0000;
            default:                  rsp_data <= 16'h0000;
         endcase
      end
   end
endmodule : qsn_top

//--- dv/qsn_host_model.sv
/*
 remote controller side: takes every answer the node puts out.
 assumes answers are one-cycle pulses on clk.
*/
`timescale 1ns/1ps
module qsn_host_model (
   // clock
   input  wire logic        clk,
   // answers from the node
   input  wire logic        rsp_valid,
   input  wire logic [15:0] rsp_data,
   input  wire logic [7:0]  rsp_text,
   // what the controller took in
   output int               answers,
   output logic [15:0]      last_code,
   output logic [7:0]       last_text
);
   // a pulse is looked at only in its own cycle, so a late sample loses it
   always @(posedge clk) begin
      if (rsp_valid === 1'b1) begin
         answers   <= answers + 1;
         last_code <= rsp_data;
         last_text <= rsp_text;
      end
   end
endmodule : qsn_host_model

//--- dv/qsn_top_sva.sv
/*
 checker of the status node top ports.
 assumes commands start only after the internal reset copy is released.
*/
`timescale 1ns/1ps
`include "qsn_consts.svh"
module qsn_top_sva (
   // clock and reset
   input wire logic              clk,
   input wire logic              rstn,
   // monitored states
   input wire logic              coh_active,
   input wire logic              power_below_limit,
   input wire logic              temp_unstable,
   input wire logic              output_protect_off,
   // commands
   input wire logic              cmd_valid,
   input wire logic              cmd_write,
   input wire qsn_pkg::qsn_sel_t cmd_sel,
   input wire logic [15:0]       cmd_data,
   // answers
   input wire logic              rsp_valid,
   input wire logic [15:0]       rsp_data,
   input wire logic              stb_ques
);
   logic [2:0] q;   // questionable states in bit order 10, 9, 7
   logic       rd;  // read request this cycle
   logic       pre; // preset request this cycle
   assign q   = {output_protect_off, temp_unstable, coh_active & power_below_limit};
   assign rd  = cmd_valid & ~cmd_write;
   assign pre = cmd_valid & (cmd_sel == qsn_pkg::QSN_SEL_PRESET);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_rsp; rd && !pre |=> rsp_valid; endproperty
   a_rsp: assert property (p_rsp) else $error("read not answered");
   property p_quiet; !rd |=> !rsp_valid; endproperty
   a_quiet: assert property (p_quiet) else $error("answer without read");
   property p_unused;
      rd && (cmd_sel == qsn_pkg::QSN_SEL_QCOND || cmd_sel == qsn_pkg::QSN_SEL_QEVENT)
      |=> (rsp_data & ~`QSN_USED_MASK) == 16'h0000;
   endproperty
   a_unused: assert property (p_unused) else $error("unused bit set");
   // the states must stay put long enough to pass the condition register
   property p_cond;
      $stable(q) [*4] ##0 (rd && cmd_sel == qsn_pkg::QSN_SEL_QCOND)
      |=> {rsp_data[10], rsp_data[9], rsp_data[7]} == $past(q);
   endproperty
   a_cond: assert property (p_cond) else $error("condition wrong");
   property p_pre_rise;
      pre ##1 !cmd_valid ##1 (rd && (cmd_sel == qsn_pkg::QSN_SEL_QRISE
      || cmd_sel == qsn_pkg::QSN_SEL_ORISE)) |=> rsp_data == `QSN_PRE_RISE;
   endproperty
   a_pre_rise: assert property (p_pre_rise) else $error("preset rise wrong");
   property p_pre_zero;
      pre ##1 !cmd_valid ##1 (rd && (cmd_sel == qsn_pkg::QSN_SEL_QFALL
      || cmd_sel == qsn_pkg::QSN_SEL_QENABLE)) |=> rsp_data == 16'h0000;
   endproperty
   a_pre_zero: assert property (p_pre_zero) else $error("preset clear wrong");
   property p_rb;
      (cmd_valid && cmd_write && (cmd_sel == qsn_pkg::QSN_SEL_QRISE
      || cmd_sel == qsn_pkg::QSN_SEL_QFALL)) ##1 !cmd_valid ##1
      (rd && cmd_sel == $past(cmd_sel, 2)) |=> rsp_data == $past(cmd_data, 3);
   endproperty
   a_rb: assert property (p_rb) else $error("mask readback wrong");
   property p_ev_clr;
      ($stable(q) [*4] ##0 (rd && cmd_sel == qsn_pkg::QSN_SEL_QEVENT)) ##1
      (!cmd_valid && $stable(q)) ##1 ($stable(q) && rd && cmd_sel == qsn_pkg::QSN_SEL_QEVENT)
      |=> rsp_data == 16'h0000;
   endproperty
   a_ev_clr: assert property (p_ev_clr) else $error("event not cleared");
   property p_stb_off; pre ##1 !cmd_valid [*5] |-> !stb_ques; endproperty
   a_stb_off: assert property (p_stb_off) else $error("summary after preset");
   c_stb: cover property ($rose(stb_ques));
   c_pre: cover property (pre);
   c_err: cover property (rd && cmd_sel == qsn_pkg::QSN_SEL_ERROR);
endmodule : qsn_top_sva
bind qsn_top qsn_top_sva u_sva (.clk(clk), .rstn(rstn), .coh_active(coh_active),
   .power_below_limit(power_below_limit), .temp_unstable(temp_unstable),
   .output_protect_off(output_protect_off), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
   .cmd_sel(cmd_sel), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
   .stb_ques(stb_ques));

//--- dv/questionable_status_node_test.sv
/*
 bench: register table rows, edge filters, preset, error queue.
 assumes the host model and checker are compiled before it.
*/
`timescale 1ns/1ps
`include "qsn_consts.svh"
module questionable_status_node_test;
   logic        clk, rstn, coh_active, power_below_limit, temp_unstable, output_protect_off;
   logic        power_excess, initializing, cmd_valid, cmd_write, err_push;
   qsn_pkg::qsn_sel_t cmd_sel;
   logic [15:0] cmd_data, err_code, rsp_data, host_code;
   logic [7:0]  err_text, rsp_text;
   logic        rsp_valid, stb_ques, stb_oper;
   int          bad_count, checked, reads, cycles, answers;
   // row: write flag, selector, write data, expected answer
   // the last pair reads the falling mask right after a preset
   logic [39:0] rows [23] = '{40'h0_3_0000_0000, 40'h1_3_0680_0000, 40'h0_3_0000_0680,
      40'h1_4_0400_0000, 40'h0_4_0000_0400, 40'h1_2_0200_0000, 40'h0_2_0000_0200,
      40'h1_8_0300_0000, 40'h0_8_0000_0300, 40'h1_0_FFFF_0000, 40'h0_0_0000_0000,
      40'h1_1_FFFF_0000, 40'h0_1_0000_0000, 40'h0_A_0000_0000, 40'h1_B_0000_0000,
      40'h0_3_0000_FFFF, 40'h0_4_0000_0000, 40'h0_2_0000_0000, 40'h0_8_0000_FFFF,
      40'h0_9_0000_0000, 40'h0_7_0000_0000, 40'h1_B_0000_0000, 40'h0_4_0000_0000};
   qsn_top u_dut (.clk(clk), .rstn(rstn), .coh_active(coh_active),
      .power_below_limit(power_below_limit), .temp_unstable(temp_unstable),
      .output_protect_off(output_protect_off), .power_excess(power_excess),
      .initializing(initializing), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_sel(cmd_sel), .cmd_data(cmd_data), .err_push(err_push), .err_code(err_code),
      .err_text(err_text), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_text(rsp_text),
      .stb_ques(stb_ques), .stb_oper(stb_oper));
   qsn_host_model u_host (.clk(clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_text(rsp_text), .answers(answers), .last_code(host_code), .last_text());
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ceiling well above the under two hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         bad_count++;
         final_report();
      end
   end
   task final_report;
      $display("mismatches %0d checks %0d", bad_count, checked);
      if (bad_count == 0 && checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : final_report
   task chk(input logic ok, input string what);
      checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("CHECK FAILED t=%0t %s", $time, what);
      end
   endtask : chk
   task wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   // one command, held for one edge; a read is answered in the next cycle
   task cmd(input logic w, input logic [3:0] s, input logic [15:0] d, input logic [15:0] e);
      wt(1);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_sel = qsn_pkg::qsn_sel_t'(s);
      cmd_data = d;
      wt(1);
      cmd_valid = 1'b0;
      if (!w) begin
         reads++;
         chk(rsp_valid === 1'b1 && rsp_data === e, "answer");
      end
   endtask : cmd
   task push(input logic [15:0] c, input logic [7:0] t);
      err_code = c;
      err_text = t;
      err_push = 1'b1;
      wt(1);
      err_push = 1'b0;
      wt(1);
   endtask : push
   initial begin
      {rstn, coh_active, power_below_limit, temp_unstable, output_protect_off} = '0;
      {power_excess, initializing, cmd_valid, cmd_write, err_push} = '0;
      {cmd_data, err_code, err_text} = '0;
      cmd_sel = qsn_pkg::QSN_SEL_QCOND;
      wt(8);
      rstn = 1'b1;
      chk(rsp_valid === 1'b0 && stb_ques === 1'b0 && stb_oper === 1'b0, "reset");
      wt(2);
      foreach (rows[i]) cmd(rows[i][36], rows[i][35:32], rows[i][31:16], rows[i][15:0]);
      cmd(1'b1, 4'h4, 16'h0400, 16'h0000);
      cmd(1'b1, 4'h2, 16'h0200, 16'h0000);
      temp_unstable = 1'b1;
      wt(6);
      chk(stb_ques === 1'b1, "summary");
      cmd(1'b0, 4'h1, 16'h0000, 16'h0200);
      cmd(1'b0, 4'h1, 16'h0000, 16'h0000);
      wt(4);
      chk(stb_ques === 1'b0, "summary clear");
      cmd(1'b0, 4'h0, 16'h0000, 16'h0200);
      cmd(1'b1, 4'h3, 16'h0000, 16'h0000);
      temp_unstable = 1'b0;
      output_protect_off = 1'b1;
      wt(3);
      output_protect_off = 1'b0;
      wt(6);
      cmd(1'b0, 4'h1, 16'h0000, 16'h0400);
      cmd(1'b1, 4'h3, 16'h0080, 16'h0000);
      coh_active = 1'b1;
      wt(6);
      cmd(1'b0, 4'h1, 16'h0000, 16'h0000);
      power_below_limit = 1'b1;
      cmd(1'b1, 4'h2, 16'h0080, 16'h0000);
      wt(6);
      chk(stb_ques === 1'b1, "coherence summary");
      cmd(1'b1, 4'hB, 16'h0000, 16'h0000);
      wt(6);
      chk(stb_ques === 1'b0, "preset summary");
      cmd(1'b0, 4'h1, 16'h0000, 16'h0080);
      {power_excess, initializing} = 2'b11;
      wt(6);
      cmd(1'b1, 4'h7, 16'h0100, 16'h0000);
      wt(4);
      chk(stb_oper === 1'b1, "operation summary");
      cmd(1'b0, 4'h6, 16'h0000, 16'h0300);
      wt(4);
      chk(stb_oper === 1'b0, "operation summary clear");
      push(16'h0000, 8'h00);
      for (int i = 0; i < 9; i++) push(16'h7FFA + i[15:0], i[7:0]);
      for (int i = 0; i < 7; i++) begin
         cmd(1'b0, 4'hA, 16'h0000, 16'h7FFA + i[15:0]);
         chk(rsp_text === i[7:0], "text");
      end
      cmd(1'b0, 4'hA, 16'h0000, `QSN_ERR_OVERFLOW);
      chk(rsp_text === 8'h00, "overflow text");
      wt(1);
      chk(host_code === `QSN_ERR_OVERFLOW, "host code");
      cmd(1'b0, 4'hA, 16'h0000, `QSN_ERR_NONE);
      wt(2);
      chk(answers == reads, "answer count");
      final_report();
   end
endmodule : questionable_status_node_test
